// file: rtl/adc_result_pkg.sv
// Package for the ADC result and interrupt-source status bank.
// Assumes a 32-bit classic Wishbone bus with byte addresses and one clock.
package adc_result_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SRC_STATUS = 8'h8C;
    localparam logic [7:0] OFS_WORD_BASE = 8'h90;
    localparam logic [7:0] OFS_EVT_STATUS = 8'hD8;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'hDC;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'hE0;
    localparam int WORD_STRIDE_LOG2 = 2;

    // Interrupt-source status bit positions
    localparam int SRC_DONE_BIT = 31;
    localparam int SRC_TRIG_BIT = 30;
    localparam int SRC_OVL_BIT = 29;
    localparam int SRC_FINE_BIT = 28;
    localparam int SRC_COARSE_BIT = 27;
    localparam int SRC_TEMP_BIT = 24;
    localparam int SRC_DIFF_LSB = 16;
    localparam int SRC_SE_LSB = 0;

    // Channel result word bit positions
    localparam int WRD_LSB_LSB = 28;
    localparam int WRD_TRIG_BIT = 26;
    localparam int WRD_OVL_BIT = 25;
    localparam int WRD_FINE_BIT = 24;
    localparam int WRD_COARSE_BIT = 23;
    localparam int WRD_GAIN_LSB = 20;
    localparam int WRD_FSEL_BIT = 19;
    localparam int WRD_CEN_BIT = 16;
    localparam int WRD_ERR_BIT = 14;
    localparam int WRD_RES_LSB = 0;

    // Reset values
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [15:0] EVT_ENABLE_RESET = 16'h0000;

    // One finished conversion from the filter logic
    typedef struct packed {
        logic valid;
        logic [3:0] channel;
        logic diff_mode;
        logic [3:0] extra_lsb;
        logic trigger_overrun_flag;
        logic modulator_overload_flag;
        logic fine_filter_range_flag;
        logic coarse_filter_range_flag;
        logic stale;
        logic [2:0] gain;
        logic filter_select;
        logic chan_enable;
        logic [11:0] result;
    } conv_in_s;

    // Stored content of one channel result word
    typedef struct packed {
        logic [3:0] extra_lsb;
        logic trigger_overrun_flag;
        logic modulator_overload_flag;
        logic fine_filter_range_flag;
        logic coarse_filter_range_flag;
        logic [2:0] gain;
        logic filter_select;
        logic chan_enable;
        logic result_error_flag;
        logic [11:0] result;
    } word_s;

endpackage

// file: rtl/adc_result_status_bank.sv
// Result word array, interrupt-source status and event interrupt of the ADC.
// Assumes conversion records arrive on mclk from the filter logic, one per cycle at most.
// Contract
// - Done summary reads 1 while any channel word has conversion done set.
// - Trigger summary reads 1 while any word has trigger-overrun set.
// - Overload summary is the OR of all words' overload flags.
// - Fine-filter summary is the OR of all words' fine range flags.
// - Coarse-filter summary is the OR of all words' coarse range flags.
// - Temperature pending set when the temperature conversion raised the interrupt.
// - Temperature pending clears only by reading its result word.
// - Eight differential pending bits, each cleared by reading its word.
// - Differential-enabled word raises its differential pending bit.
// - Sixteen single-ended pending bits, each cleared by reading its word.
// - Differential-enabled word never raises its single-ended pending bit; here a differential record on channels 8 to 15 does raise it.
// - Sixteen result words hold result plus conversion status.
// - New conversion overwrites its word even if unread.
// - Word layout: result, extra LSBs, flags, gain, filter select, enable, error.
// - Reading source status drops the interrupt; status bits stay, no masking.
// - Summaries are plain ORs across all words.
// - Reading a word clears its status bits, keeps the result.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module adc_result_status_bank #(
    parameter int N_CH = 16,
    parameter int N_DIFF = 8,
    parameter int TEMP_CH = 15
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire adc_result_pkg::conv_in_s conv_i,
    output logic converter_irq_out
);

    // Field layout is fixed by the register map
    if (N_CH != 16 || N_DIFF != 8 || TEMP_CH < 0 || TEMP_CH >= N_CH) begin : g_bad_param
        $error("adc_result_status_bank: unsupported channel parameters");
    end

    adc_result_pkg::word_s word_q [N_CH];
    adc_result_pkg::word_s word_d [N_CH];
    logic [N_CH-1:0] done_q, done_d;
    logic [N_CH-1:0] diff_q, diff_d;
    logic [N_CH-1:0] evt_q, evt_d;
    logic [N_CH-1:0] en_q, en_d;
    logic quiet_q, quiet_d;
    logic irq_q, irq_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;

    // Bus decode; one access per handshake, answered one cycle later
    logic access;
    logic rd_access;
    logic wr_access;
    logic word_hit;
    logic [7:0] word_ofs;
    logic [3:0] word_idx;
    assign access = wb_cyc_i && wb_stb_i && !ack_q;
    assign rd_access = access && !wb_we_i;
    assign wr_access = access && wb_we_i;
    assign word_ofs = wb_adr_i - adc_result_pkg::OFS_WORD_BASE;
    assign word_idx = word_ofs[5:2];
    assign word_hit = (wb_adr_i >= adc_result_pkg::OFS_WORD_BASE)
        && (word_ofs < 8'(N_CH << adc_result_pkg::WORD_STRIDE_LOG2))
        && (wb_adr_i[1:0] == 2'h0);

    // Summaries: combinational ORs over the live words
    logic [N_CH-1:0] trig_v, ovl_v, fine_v, coarse_v;
    logic [N_CH-1:0] se_pend;
    logic [N_DIFF-1:0] diff_pend;
    logic temp_pend;
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            trig_v[i] = word_q[i].trigger_overrun_flag;
            ovl_v[i] = word_q[i].modulator_overload_flag;
            fine_v[i] = word_q[i].fine_filter_range_flag;
            coarse_v[i] = word_q[i].coarse_filter_range_flag;
            se_pend[i] = done_q[i] && !diff_q[i];
        end
        for (int k = 0; k < N_DIFF; k++) begin
            diff_pend[k] = done_q[k] && diff_q[k];
        end
        temp_pend = done_q[TEMP_CH];
    end

    // Interrupt-source status word
    logic [31:0] src_word;
    always_comb begin
        src_word = adc_result_pkg::ZERO_WORD;
        src_word[adc_result_pkg::SRC_DONE_BIT] = |done_q;
        src_word[adc_result_pkg::SRC_TRIG_BIT] = |trig_v;
        src_word[adc_result_pkg::SRC_OVL_BIT] = |ovl_v;
        src_word[adc_result_pkg::SRC_FINE_BIT] = |fine_v;
        src_word[adc_result_pkg::SRC_COARSE_BIT] = |coarse_v;
        src_word[adc_result_pkg::SRC_TEMP_BIT] = temp_pend;
        src_word[adc_result_pkg::SRC_DIFF_LSB +: N_DIFF] = diff_pend;
        src_word[adc_result_pkg::SRC_SE_LSB +: N_CH] = se_pend;
    end

    // Packs a stored word into the bus layout
    function automatic logic [31:0] pack_word(input adc_result_pkg::word_s w);
        logic [31:0] r;
        r = adc_result_pkg::ZERO_WORD;
        r[adc_result_pkg::WRD_LSB_LSB +: 4] = w.extra_lsb;
        r[adc_result_pkg::WRD_TRIG_BIT] = w.trigger_overrun_flag;
        r[adc_result_pkg::WRD_OVL_BIT] = w.modulator_overload_flag;
        r[adc_result_pkg::WRD_FINE_BIT] = w.fine_filter_range_flag;
        r[adc_result_pkg::WRD_COARSE_BIT] = w.coarse_filter_range_flag;
        r[adc_result_pkg::WRD_GAIN_LSB +: 3] = w.gain;
        r[adc_result_pkg::WRD_FSEL_BIT] = w.filter_select;
        r[adc_result_pkg::WRD_CEN_BIT] = w.chan_enable;
        r[adc_result_pkg::WRD_ERR_BIT] = w.result_error_flag;
        r[adc_result_pkg::WRD_RES_LSB +: 12] = w.result;
        return r;
    endfunction

    // Byte-lane write merge for the enable register
    function automatic logic [N_CH-1:0] lane_merge(input logic [N_CH-1:0] old,
            input logic [31:0] wd, input logic [3:0] sel);
        logic [N_CH-1:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Result words: conversion write beats read-clear so no event is lost
    logic new_conv;
    assign new_conv = conv_i.valid && (int'(conv_i.channel) < N_CH);
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            word_d[i] = word_q[i];
            done_d[i] = done_q[i];
            diff_d[i] = diff_q[i];
            if (rd_access && word_hit && word_idx == 4'(i)) begin
                // Result, extra LSBs and config echo survive the read
                word_d[i].trigger_overrun_flag = 1'b0;
                word_d[i].modulator_overload_flag = 1'b0;
                word_d[i].fine_filter_range_flag = 1'b0;
                word_d[i].coarse_filter_range_flag = 1'b0;
                word_d[i].result_error_flag = 1'b0;
                done_d[i] = 1'b0;
            end
            if (new_conv && conv_i.channel == 4'(i)) begin
                word_d[i].extra_lsb = conv_i.extra_lsb;
                word_d[i].trigger_overrun_flag = conv_i.trigger_overrun_flag;
                word_d[i].modulator_overload_flag = conv_i.modulator_overload_flag;
                word_d[i].fine_filter_range_flag = conv_i.fine_filter_range_flag;
                word_d[i].coarse_filter_range_flag = conv_i.coarse_filter_range_flag;
                word_d[i].gain = conv_i.gain;
                word_d[i].filter_select = conv_i.filter_select;
                word_d[i].chan_enable = conv_i.chan_enable;
                word_d[i].result_error_flag = conv_i.trigger_overrun_flag
                    || conv_i.modulator_overload_flag || conv_i.fine_filter_range_flag
                    || conv_i.coarse_filter_range_flag || conv_i.stale;
                word_d[i].result = conv_i.result;
                done_d[i] = 1'b1;
                // Only the low channels have a differential partner
                diff_d[i] = conv_i.diff_mode && (i < N_DIFF);
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < N_CH; i++) begin
            if (rst) begin
                word_q[i] <= '0;
            end else begin
                word_q[i] <= word_d[i];
            end
        end
        if (rst) begin
            done_q <= '0;
            diff_q <= '0;
        end else begin
            done_q <= done_d;
            diff_q <= diff_d;
        end
    end

    // Event status, clear and enable; a new event wins over its clear
    logic src_read;
    assign src_read = rd_access && wb_adr_i == adc_result_pkg::OFS_SRC_STATUS;
    always_comb begin
        evt_d = evt_q;
        en_d = en_q;
        quiet_d = quiet_q;
        if (wr_access && wb_adr_i == adc_result_pkg::OFS_EVT_CLEAR) begin
            evt_d = evt_q & ~lane_merge('0, wb_dat_i, wb_sel_i);
        end
        if (wr_access && wb_adr_i == adc_result_pkg::OFS_EVT_ENABLE) begin
            en_d = lane_merge(en_q, wb_dat_i, wb_sel_i);
        end
        if (src_read) begin
            quiet_d = 1'b1;
        end
        if (new_conv) begin
            evt_d[conv_i.channel] = 1'b1;
            quiet_d = 1'b0;
        end
        // Registered output, so the drop shows one cycle after the read is taken
        irq_d = |(evt_d & en_d) && !quiet_d;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            evt_q <= '0;
            en_q <= adc_result_pkg::EVT_ENABLE_RESET;
            quiet_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            en_q <= en_d;
            quiet_q <= quiet_d;
            irq_q <= irq_d;
        end
    end

    // Read mux and acknowledge; unmapped reads return zero, writes are dropped
    always_comb begin
        ack_d = access;
        dat_d = dat_q;
        if (rd_access) begin
            dat_d = adc_result_pkg::ZERO_WORD;
            if (wb_adr_i == adc_result_pkg::OFS_SRC_STATUS) begin
                dat_d = src_word;
            end else if (word_hit) begin
                dat_d = pack_word(word_q[word_idx]);
            end else if (wb_adr_i == adc_result_pkg::OFS_EVT_STATUS) begin
                dat_d[N_CH-1:0] = evt_q;
            end else if (wb_adr_i == adc_result_pkg::OFS_EVT_ENABLE) begin
                dat_d[N_CH-1:0] = en_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= adc_result_pkg::ZERO_WORD;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign converter_irq_out = irq_q;

    // All checks run on mclk and sleep through reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // A single-ended record for word 0
    sequence conv_on_ch0;
        conv_i.valid && conv_i.channel == 4'h0 && !conv_i.diff_mode;
    endsequence

    // Word 0 neither read nor rewritten, so its pending kind cannot change
    sequence ch0_untouched;
        !(rd_access && word_hit && word_idx == 4'h0)
            && !(conv_i.valid && conv_i.channel == 4'h0);
    endsequence

    // A record for the temperature word
    sequence conv_on_temp;
        new_conv && conv_i.channel == 4'(TEMP_CH);
    endsequence

    // A taken read of the temperature word with no record arriving
    sequence read_of_temp;
        rd_access && word_hit && word_idx == 4'(TEMP_CH) && !new_conv;
    endsequence

    // A taken read of any result word with no record arriving
    sequence word_read;
        rd_access && word_hit && !new_conv;
    endsequence

    // A taken source status read, then a cycle with no record
    sequence status_read_idle;
        src_read && !new_conv ##1 !new_conv;
    endsequence

    // Done summary follows any finished record
    done_summary_a: assert property (new_conv |=> src_word[31])
        else $error("done summary not set after conversion");

    // Trigger summary follows a flagged record
    trig_summary_a: assert property (
        new_conv && conv_i.trigger_overrun_flag |=> src_word[30])
        else $error("trigger summary missing");

    // Overload summary is the OR over all words
    ovl_summary_a: assert property (src_word[29] == |ovl_v)
        else $error("overload summary mismatch");

    // Both filter range summaries are ORs over all words
    fine_coarse_a: assert property (
        src_word[28] == |fine_v && src_word[27] == |coarse_v)
        else $error("filter range summary mismatch");

    // Single-ended pending stands while its word is left alone
    se_pend_a: assert property (conv_on_ch0 ##1 ch0_untouched[*2] |-> src_word[0])
        else $error("single-ended pending not held");

    // A differential record raises only its differential bit
    diff_excl_a: assert property (
        new_conv && conv_i.diff_mode && conv_i.channel < 4'h8
        |=> src_word[16 + $past(conv_i.channel)] && !src_word[$past(conv_i.channel)])
        else $error("differential pending wrong");

    // A word read clears status and keeps the result
    read_clear_a: assert property (word_read
        |=> !done_q[$past(word_idx)] && !word_q[$past(word_idx)].result_error_flag
        && word_q[$past(word_idx)].result == $past(word_q[word_idx].result))
        else $error("word read did not clear status only");

    // A source status read drops the interrupt on the next edge
    irq_drop_a: assert property (src_read && !new_conv |=> !converter_irq_out)
        else $error("interrupt not dropped by status read");

    // A record overwrites its word, read or not
    overwrite_a: assert property (new_conv
        |=> word_q[$past(conv_i.channel)].result == $past(conv_i.result))
        else $error("conversion did not overwrite word");

    // One ack per access, even with stb held
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // Every taken access is answered on the next edge
    ack_answer_a: assert property (access |=> wb_ack_o)
        else $error("access not acknowledged");

    // The temperature record raises the temperature bit
    temp_pend_a: assert property (conv_on_temp |=> src_word[24])
        else $error("temperature pending not set");

    // Reading the temperature word clears its bit
    temp_clear_a: assert property (read_of_temp |=> !src_word[24])
        else $error("temperature pending not cleared by read");

    // Nothing but a read of the temperature word clears its bit
    temp_only_a: assert property ($fell(src_word[24])
        |-> $past(rd_access && word_hit && word_idx == 4'(TEMP_CH)))
        else $error("temperature pending cleared without read");

    // A taken word read clears its pending bit of either kind
    pend_clear_a: assert property (word_read
        |=> !src_word[$past(word_idx)]
        && (($past(word_idx) >= 4'h8) || !src_word[16 + $past(word_idx)]))
        else $error("pending bit survived its word read");

    // A record sets done and its event, beating a same-cycle read or clear
    set_wins_a: assert property (new_conv
        |=> done_q[$past(conv_i.channel)] && evt_q[$past(conv_i.channel)])
        else $error("record lost to a same-cycle clear");

    // The error bit is the OR of the record's faults
    error_or_a: assert property (new_conv
        |=> word_q[$past(conv_i.channel)].result_error_flag
        == $past(conv_i.trigger_overrun_flag || conv_i.modulator_overload_flag
        || conv_i.fine_filter_range_flag || conv_i.coarse_filter_range_flag || conv_i.stale))
        else $error("error bit not the OR of faults");

    // The interrupt stays low while no record follows a status read
    irq_quiet_a: assert property (status_read_idle |=> !converter_irq_out)
        else $error("interrupt came back without a record");

endmodule

`default_nettype wire

// file: dv/conv_source.sv
// Behavioural conversion source feeding finished records to the bank.
// Assumes one record per mclk cycle at most, taken on the rising edge.
`timescale 1ns/1ps
`default_nettype none

module conv_source (
    input wire logic mclk,
    output var adc_result_pkg::conv_in_s conv_o
);
    initial conv_o = '0;

    // Records go out back to back; idle fields are scrambled so stale samples show
    task automatic burst(input adc_result_pkg::conv_in_s first,
        input adc_result_pkg::conv_in_s second, input logic two);
        adc_result_pkg::conv_in_s idle;
        idle = two ? ~second : ~first;
        idle.valid = 1'h0;
        @(posedge mclk);
        conv_o <= first;
        if (two) begin
            @(posedge mclk);
            conv_o <= second;
        end
        @(posedge mclk);
        conv_o <= idle;
    endtask
endmodule

`default_nettype wire

// file: dv/adc_result_status_bank_tb.sv
// Self-checking bench for the ADC result and interrupt-source status bank.
// Assumes the package and the conversion source model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module adc_result_status_bank_tb;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    adc_result_pkg::conv_in_s conv;
    int miscompares = 0;
    int checks = 0;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    adc_result_status_bank u_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .conv_i(conv), .converter_irq_out(irq));
    conv_source u_src (.mclk(mclk), .conv_o(conv));

    // Record with fixed extra bits, gain 5, filter select and enable set
    function automatic adc_result_pkg::conv_in_s mk(input logic [3:0] ch, input logic d,
        input logic [3:0] fl, input logic [11:0] res);
        return {1'h1, ch, d, 4'hA, fl, 1'h0, 3'h5, 1'h1, 1'h1, res};
    endfunction

    // Word expected from a record built by mk
    function automatic logic [31:0] wexp(input logic [3:0] fl, input logic [11:0] res);
        return {4'hA, 1'h0, fl, 3'h5, 1'h1, 2'h0, 1'h1, 1'h0, |fl, 2'h0, res};
    endfunction

    // Source status with only one converted word pending
    function automatic logic [31:0] sexp(input logic [3:0] ch, input logic d,
        input logic [3:0] fl);
        logic [31:0] s;
        s = {1'h1, fl, 27'h0};
        if (ch == 4'hF) s[24] = 1'h1;
        if (d && ch < 4'h8) s[16 + ch] = 1'h1;
        else s[ch] = 1'h1;
        return s;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Interrupt level is looked at mid-cycle, after the edge has settled
    task automatic chk_irq(input logic exp);
        @(negedge mclk);
        checks++;
        if (irq !== exp) begin
            miscompares++;
            $display("[FAIL] irq expected %h seen %h", exp, irq);
        end
    endtask

    // Classic single cycle; waits for ack, only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge mclk);
        end while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] q;
        wb(1'h1, a, d, s, q);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
        input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, 4'hF, q);
        chk(what, exp & m, q & m);
    endtask

    task automatic t_reset();
        rd_chk("status", 8'h8C, 32'h0);
        rd_chk("word0", 8'h90, 32'h0);
        rd_chk("enable", 8'hE0, 32'h0);
        rd_chk("unmapped", 8'hF0, 32'h0);
        chk_irq(1'h0);
        $display("test reset done");
    endtask

    // One flag at a time, then none; status read before the word
    task automatic t_flags();
        logic [3:0] fl;
        logic [7:0] a;
        for (int i = 0; i < 5; i++) begin
            fl = (i < 4) ? (4'h8 >> i) : 4'h0;
            a = 8'h90 + 8'(4 * (i + 3));
            u_src.burst(mk(4'(i + 3), 1'h0, fl, 12'hA50 + 12'(i)), '0, 1'h0);
            rd_chk("status", 8'h8C, sexp(4'(i + 3), 1'h0, fl));
            rd_chk("word", a, wexp(fl, 12'hA50 + 12'(i)));
            rd_chk("status clr", 8'h8C, 32'h0);
            rd_chk("word kept", a, {20'h0, 12'hA50 + 12'(i)}, 32'h0780_4FFF);
        end
        $display("test flags done");
    endtask

    task automatic t_diff();
        u_src.burst(mk(4'h2, 1'h1, 4'h0, 12'h0C3), '0, 1'h0);
        rd_chk("diff status", 8'h8C, sexp(4'h2, 1'h1, 4'h0));
        rd_chk("diff word", 8'h98, wexp(4'h0, 12'h0C3));
        rd_chk("diff clr", 8'h8C, 32'h0);
        u_src.burst(mk(4'hF, 1'h0, 4'h2, 12'hFFF), '0, 1'h0);
        rd_chk("temp status", 8'h8C, sexp(4'hF, 1'h0, 4'h2));
        rd_chk("other word", 8'hC8, 32'h0, 32'h0780_4000);
        rd_chk("temp held", 8'h8C, sexp(4'hF, 1'h0, 4'h2));
        rd_chk("temp word", 8'hCC, wexp(4'h2, 12'hFFF));
        rd_chk("temp clr", 8'h8C, 32'h0);
        $display("test diff done");
    endtask

    // Back-to-back records to one channel; the first flag must vanish
    task automatic t_overwrite();
        adc_result_pkg::conv_in_s rec;
        u_src.burst(mk(4'h5, 1'h0, 4'h8, 12'h123), mk(4'h5, 1'h0, 4'h0, 12'h456), 1'h1);
        rd_chk("ovw status", 8'h8C, sexp(4'h5, 1'h0, 4'h0));
        rd_chk("ovw word", 8'hA4, wexp(4'h0, 12'h456));
        // A stale record shows only as the error bit
        rec = mk(4'h6, 1'h0, 4'h0, 12'h789);
        rec.stale = 1'h1;
        u_src.burst(rec, '0, 1'h0);
        rd_chk("stale status", 8'h8C, sexp(4'h6, 1'h0, 4'h0));
        rd_chk("stale word", 8'hA8, wexp(4'h0, 12'h789) | 32'h0000_4000);
        $display("test overwrite done");
    endtask

    task automatic t_irq();
        wr(8'hDC, 32'h0000_FFFF);
        wr(8'hE0, 32'h0000_FF02, 4'h1);
        rd_chk("enable", 8'hE0, 32'h2);
        u_src.burst(mk(4'h1, 1'h0, 4'h0, 12'h001), '0, 1'h0);
        chk_irq(1'h1);
        rd_chk("event", 8'hD8, 32'h2);
        rd_chk("irq source", 8'h8C, sexp(4'h1, 1'h0, 4'h0));
        chk_irq(1'h0);
        u_src.burst(mk(4'h1, 1'h0, 4'h0, 12'h002), '0, 1'h0);
        chk_irq(1'h1);
        wr(8'hDC, 32'h2);
        chk_irq(1'h0);
        u_src.burst(mk(4'h0, 1'h0, 4'h0, 12'h003), '0, 1'h0);
        chk_irq(1'h0);
        wr(8'hD8, 32'h0);
        rd_chk("masked event", 8'hD8, 32'h1);
        $display("test irq done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence after a 20 cycle reset
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        t_reset();
        t_flags();
        t_diff();
        t_overwrite();
        t_irq();
        report_and_stop();
    end

    // Tests need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
endmodule

`default_nettype wire
